// File: verilog/programmed_operator_trap.sv
// Fetch, decode and trap sequencer for programmed-operator instructions.
// Assumes a memory answering each request with mem_ack; data valid with the ack.
module programmed_operator_trap (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [23:0] mem_rdata,
    input  wire logic        mem_ack,
    input  wire logic        overflow_set,
    output logic             mem_req_ff,
    output logic             mem_we_ff,
    output logic [13:0]      mem_addr_ff,
    output logic [23:0]      mem_wdata_ff,
    output logic             overflow_ff,
    output logic [13:0]      pc_ff,
    output logic             exec_ff,
    output logic [23:0]      instr_ff
);
    pop_trap_pkg::state_t state_ff, nxt_state;
    logic        nxt_req, nxt_we, nxt_ovf, nxt_exec;
    logic        chain_ff, nxt_chain;
    logic [13:0] nxt_addr, nxt_pc;
    logic [23:0] nxt_wdata, nxt_instr;

    function automatic logic [7:0] opc(input logic [23:0] w);
        opc = w[pop_trap_pkg::OPC_HI:pop_trap_pkg::OPC_LO];
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_req   = 1'b0;
        nxt_we    = 1'b0;
        nxt_addr  = mem_addr_ff;
        nxt_wdata = mem_wdata_ff;
        nxt_ovf   = overflow_ff | overflow_set;
        nxt_pc    = pc_ff;
        nxt_exec  = 1'b0;
        nxt_instr = instr_ff;
        nxt_chain = chain_ff;
        case (state_ff)
            pop_trap_pkg::ST_FETCH: begin
                nxt_req   = 1'b1;
                nxt_addr  = pc_ff;
                if (mem_req_ff && mem_ack) begin
                    nxt_req   = 1'b0;
                    nxt_instr = mem_rdata;
                    nxt_state = pop_trap_pkg::ST_DECODE;
                end
            end
            pop_trap_pkg::ST_DECODE: begin
                if (instr_ff[pop_trap_pkg::POP_BIT]) begin
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b1;
                    nxt_addr  = pop_trap_pkg::SAVE_ADDR;
                    nxt_wdata = pop_trap_pkg::WORD_ZERO;
                    nxt_wdata[pop_trap_pkg::ADDR_W-1:0] = pc_ff;
                    nxt_wdata[pop_trap_pkg::IND_BIT] = 1'b1;
                    nxt_wdata[pop_trap_pkg::SIGN_BIT] = nxt_ovf;
                    nxt_ovf   = 1'b0;
                    nxt_state = pop_trap_pkg::ST_SAVE;
                end else if (opc(instr_ff) == pop_trap_pkg::OPC_RETURN
                             || opc(instr_ff) == pop_trap_pkg::OPC_BRANCH) begin
                    nxt_addr  = instr_ff[pop_trap_pkg::ADDR_W-1:0];
                    if (instr_ff[pop_trap_pkg::IND_BIT]) begin
                        nxt_req   = 1'b1;
                        nxt_chain = 1'b1;
                        nxt_state = pop_trap_pkg::ST_INDIR;
                    end else if (opc(instr_ff) == pop_trap_pkg::OPC_RETURN) begin
                        nxt_req   = 1'b1;
                        nxt_chain = 1'b0;
                        nxt_state = pop_trap_pkg::ST_INDIR;
                    end else begin
                        nxt_chain = 1'b0;
                        nxt_state = pop_trap_pkg::ST_RET;
                    end
                end else begin
                    nxt_exec  = 1'b1;
                    nxt_pc    = 14'(pc_ff + 14'h0001);
                    nxt_state = pop_trap_pkg::ST_EXEC;
                end
            end
            pop_trap_pkg::ST_SAVE: begin
                nxt_req = 1'b1;
                nxt_we  = 1'b1;
                if (mem_ack) begin
                    nxt_req   = 1'b0;
                    nxt_we    = 1'b0;
                    nxt_pc    = {7'h00, instr_ff[pop_trap_pkg::CODE_HI:pop_trap_pkg::CODE_LO]};
                    nxt_state = pop_trap_pkg::ST_FETCH;
                end
            end
            pop_trap_pkg::ST_INDIR: begin
                nxt_req = 1'b1;
                if (mem_ack) begin
                    if (chain_ff) begin
                        // Pointer read: follow while the word is flagged indirect
                        nxt_addr = mem_rdata[pop_trap_pkg::ADDR_W-1:0];
                        if (!mem_rdata[pop_trap_pkg::IND_BIT]) begin
                            nxt_chain = 1'b0;
                            if (opc(instr_ff) != pop_trap_pkg::OPC_RETURN) begin
                                nxt_req   = 1'b0;
                                nxt_state = pop_trap_pkg::ST_RET;
                            end
                        end
                    end else begin
                        // Return word read at the effective address
                        nxt_req   = 1'b0;
                        nxt_wdata = mem_rdata;
                        nxt_state = pop_trap_pkg::ST_RET;
                    end
                end
            end
            pop_trap_pkg::ST_RET: begin
                if (opc(instr_ff) == pop_trap_pkg::OPC_RETURN) begin
                    nxt_pc  = 14'(mem_wdata_ff[pop_trap_pkg::ADDR_W-1:0] + 14'h0001);
                    nxt_ovf = overflow_ff | mem_wdata_ff[pop_trap_pkg::SIGN_BIT];
                end else begin
                    nxt_pc = mem_addr_ff;
                end
                nxt_state = pop_trap_pkg::ST_FETCH;
            end
            pop_trap_pkg::ST_EXEC: begin
                nxt_state = pop_trap_pkg::ST_FETCH;
            end
            default: begin
                nxt_state = pop_trap_pkg::ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff     <= pop_trap_pkg::ST_FETCH;
            mem_req_ff   <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_addr_ff  <= pop_trap_pkg::SAVE_ADDR;
            mem_wdata_ff <= pop_trap_pkg::WORD_ZERO;
            overflow_ff  <= 1'b0;
            pc_ff        <= pop_trap_pkg::RESET_PC;
            exec_ff      <= 1'b0;
            instr_ff     <= pop_trap_pkg::WORD_ZERO;
            chain_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            mem_req_ff   <= nxt_req;
            mem_we_ff    <= nxt_we;
            mem_addr_ff  <= nxt_addr;
            mem_wdata_ff <= nxt_wdata;
            overflow_ff  <= nxt_ovf;
            pc_ff        <= nxt_pc;
            exec_ff      <= nxt_exec;
            instr_ff     <= nxt_instr;
            chain_ff     <= nxt_chain;
        end
    end
endmodule // programmed_operator_trap

// File: common/pop_trap_pkg.sv
// Constants for the programmed-operator trap sequencer.
// Assumes a 24-bit word, bit 0 the sign (most significant) bit.
package pop_trap_pkg;
    localparam int          WORD_W      = 24;
    localparam int          ADDR_W      = 14;
    // Bit n in word numbering is vector index (WORD_W-1-n)
    localparam int          POP_BIT     = 21;  // word bit 2
    localparam int          IND_BIT     = 14;  // word bit 9
    localparam int          SIGN_BIT    = 23;  // word bit 0
    localparam int          CODE_HI     = 21;  // word bits 2..8
    localparam int          CODE_LO     = 15;
    localparam int          OPC_HI      = 22;  // word bits 1..8
    localparam int          OPC_LO      = 15;
    localparam logic [13:0] SAVE_ADDR   = 14'h0000;
    localparam logic [13:0] RESET_PC    = 14'h0000;
    localparam logic [7:0]  OPC_RETURN  = 8'h29;  // octal 51
    localparam logic [7:0]  OPC_BRANCH  = 8'h01;  // octal 01
    localparam logic [23:0] WORD_ZERO   = 24'h000000;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_DECODE = 3'b001,
        ST_SAVE  = 3'b011,
        ST_INDIR = 3'b010,
        ST_RET   = 3'b110,
        ST_EXEC  = 3'b111
    } state_t;
endpackage

// File: test/programmed_operator_trap_checker.sv
// Port checker for the trap sequencer
// Assumes binding onto programmed_operator_trap
module programmed_operator_trap_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [23:0] mem_rdata,
    input wire logic        mem_ack,
    input wire logic        overflow_set,
    input wire logic        mem_req_ff,
    input wire logic        mem_we_ff,
    input wire logic [13:0] mem_addr_ff,
    input wire logic [23:0] mem_wdata_ff,
    input wire logic        overflow_ff,
    input wire logic [13:0] pc_ff,
    input wire logic        exec_ff,
    input wire logic [23:0] instr_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence save_done;
        mem_we_ff && mem_ack;
    endsequence
    a_save_after_trap: assert property ($rose(mem_we_ff) |-> instr_ff[21])
        else $error("save without trapped word");
    a_no_exec_trap: assert property (exec_ff |-> !instr_ff[21])
        else $error("trapped word executed");
    a_save_to_zero: assert property (mem_we_ff |-> mem_addr_ff == 14'h0000)
        else $error("save address not zero");
    a_ind_flag_set: assert property (mem_we_ff |-> mem_wdata_ff[14])
        else $error("indirect flag clear");
    a_save_format: assert property (mem_we_ff |-> mem_wdata_ff[22:15] == 8'h00)
        else $error("saved word format bad");
    a_ovf_cleared: assert property (mem_we_ff && !$past(overflow_set) |-> !overflow_ff)
        else $error("overflow not cleared");
    a_link_pc: assert property (save_done |=> pc_ff == {7'h00, instr_ff[21:15]})
        else $error("linkage address wrong");
    a_link_fetch: assert property (save_done |-> ##[1:4]
        (mem_req_ff && !mem_we_ff && mem_addr_ff == pc_ff)) else $error("no linkage fetch");
endmodule // programmed_operator_trap_checker

// File: test/core_memory_model.sv
// Core memory answering each request with one ack pulse
// Assumes requests stand until acked
module core_memory_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [13:0] addr,
    input  wire logic [23:0] wdata,
    output logic             ack,
    output logic [23:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] mem [16384];
    initial begin
        ack = 1'b0;
        rdata = 24'h000000;
    end
    always @(posedge clk) begin
        ack <= req && !ack && !slow;
        rdata <= (req && !ack && !slow) ? mem[addr] : ~rdata;
        if (req && ack && we) mem[addr] <= wdata;
    end
endmodule // core_memory_model

// File: test/programmed_operator_trap_bench.sv
// Bench for the trap sequencer against a core memory model
// Assumes checker and memory model compile first
bind programmed_operator_trap programmed_operator_trap_checker chk_u (.clk(clk), .rst_b(rst_b),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .overflow_set(overflow_set),
    .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .overflow_ff(overflow_ff), .pc_ff(pc_ff),
    .exec_ff(exec_ff), .instr_ff(instr_ff));
module programmed_operator_trap_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, ack, ovf_set, slow, req, we, ovf, exec;
    logic [13:0] addr, pc;
    logic [23:0] rdata, wdata, instr;
    int failures = 0;
    int samples_checked = 0;
    programmed_operator_trap dut_u (.clk(clk), .rst_b(rst_b), .mem_rdata(rdata), .mem_ack(ack),
        .overflow_set(ovf_set), .mem_req_ff(req), .mem_we_ff(we), .mem_addr_ff(addr),
        .mem_wdata_ff(wdata), .overflow_ff(ovf), .pc_ff(pc), .exec_ff(exec), .instr_ff(instr));
    core_memory_model mem_u (.clk(clk), .slow(slow), .req(req), .we(we), .addr(addr),
        .wdata(wdata), .ack(ack), .rdata(rdata));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_pc(input logic [13:0] a);
        for (int n = 0; n < 300 && pc !== a; n++) @(posedge clk) #1;
        check({10'h000, pc}, {10'h000, a});
        if (pc !== a) final_report();
    endtask
    task automatic trap_with_overflow();
        wait_pc(14'h0060);
        check(mem_u.mem[0], 24'h804000);
        check({23'h0, ovf}, 24'h000000);
        for (int n = 0; n < 20 && exec !== 1'b1; n++) @(posedge clk) #1;
        check({23'h0, exec}, 24'h000001);
        check(instr, 24'h0405a5);
    endtask
    task automatic trap_and_return();
        wait_pc(14'h0200);
        slow = 1'b1;
        repeat (3) @(posedge clk) #1;
        slow = 1'b0;
        wait_pc(14'h007f);
        check(mem_u.mem[0], 24'h004200);
        wait_pc(14'h0201);
        check({23'h0, ovf}, 24'h000000);
        wait_pc(14'h0123);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        ovf_set = 1'b0;
        slow = 1'b0;
        for (int i = 0; i < 16384; i++) mem_u.mem[i] = 24'h000000;
        mem_u.mem[0] = 24'h3002e2;
        mem_u.mem[14'h60] = 24'h0405a5;
        mem_u.mem[14'h62] = 24'h008200;
        mem_u.mem[14'h200] = 24'h3f8123;
        mem_u.mem[14'h7f] = 24'h148000;
        mem_u.mem[14'h201] = 24'h00c000;
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        ovf_set = 1'b1;
        @(posedge clk) #1 ovf_set = 1'b0;
        trap_with_overflow();
        trap_and_return();
        final_report();
    end
endmodule // programmed_operator_trap_bench
